// >>> include/eagen_consts.svh
// Purpose: Constants for the effective address generator.
// Assumes: 32-bit addresses, eight data and eight address registers.
// Notes: Mode codes live in the package as an enum.
// Behaviour
// - Operands may be bits, BCD digits, bytes, words or long words.
// - Fourteen addressing modes in six groups are implemented.
// - Absolute short uses one extension word; absolute long uses two.
// - PC relative adds 16-bit displacement; indexed form adds index and 8-bit.
// - Indexed PC relative address is PC plus index plus short displacement.
// - Postincrement uses current pointer, then adds operand size to it.
// - Predecrement subtracts operand size first, then uses the new pointer.
// - Pointer step is 1 for byte, 2 for word, 4 for long word.
// - Displacement mode adds 16-bit extension displacement to address register.
// - Indexed indirect adds address register, index register and 8-bit displacement.
// - Index register may be any address or data register.
// - Indexed displacement is eight bits; plain displacement is sixteen bits.
// - Implied mode names status register, user or active stack pointer, or PC.
`ifndef EAGEN_CONSTS_SVH
`define EAGEN_CONSTS_SVH
`define STEP_BYTE 32'h0000_0001
`define STEP_WORD 32'h0000_0002
`define STEP_LONG 32'h0000_0004
`define ZERO32 32'h0000_0000
`define BYTE_MASK 32'h0000_00FF
`define WORD_MASK 32'h0000_FFFF
`define QUICK_W 8
`define SP_REG_NUM 3'h7
`endif

// >>> include/eagen_pkg.sv
// Purpose: Types for the effective address generator.
// Assumes: Nothing beyond the constants header.
// Notes: Request and result travel as packed structs.
package eagen_pkg;
    typedef enum logic [3:0] {
        M_DATA_DIRECT, M_ADDR_DIRECT, M_ABS_SHORT, M_ABS_LONG,
        M_PC_DISP, M_PC_INDEX, M_INDIRECT, M_POSTINC, M_PREDEC,
        M_DISP, M_INDEX, M_IMMEDIATE, M_QUICK, M_IMPLIED
    } mode_t;
    typedef enum logic [1:0] {SZ_BYTE, SZ_WORD, SZ_LONG} size_t;
    typedef enum logic [1:0] {IMP_SR, IMP_USP, IMP_SP, IMP_PC} implied_t;
    typedef struct packed {
        mode_t mode;
        size_t size;
        logic [2:0] reg_num;
        logic index_is_addr;
        logic [2:0] index_num;
        logic index_long;
        implied_t implied_sel;
        logic [15:0] ext_word0;
        logic [15:0] ext_word1;
        logic [7:0] quick_data;
    } request_t;
    typedef struct packed {
        logic is_address;
        logic [31:0] value;
        logic ptr_write;
        logic [2:0] ptr_num;
        logic [31:0] ptr_value;
    } result_t;
endpackage

// >>> rtl/eagen.sv
// Purpose: Effective address generator registered one cycle behind its request.
// Assumes: Register file values arrive as flat buses from the same clock domain.
// Notes: Bit and BCD operands address as bytes; the ALU picks the bit or digit.
`timescale 1ns/1ps
`include "eagen_consts.svh"
module effective_address_generator (
    input wire logic I_CLK,
    input wire logic I_RESET_N,
    input wire logic I_REQ_VALID,
    input wire eagen_pkg::request_t I_REQ,
    input wire logic [255:0] I_DATA_REGS,
    input wire logic [255:0] I_ADDR_REGS,
    input wire logic [31:0] I_PC,
    input wire logic [31:0] I_STATUS,
    input wire logic [31:0] I_USER_STACK_PTR,
    output logic O_VALID,
    output eagen_pkg::result_t O_RESULT
);
    // Sign extension helpers for displacements and word index values.
    function automatic logic [31:0] sext16(input logic [15:0] v);
        sext16 = {{16{v[15]}}, v};
    endfunction
    function automatic logic [31:0] sext8(input logic [7:0] v);
        sext8 = {{24{v[7]}}, v};
    endfunction
    function automatic logic [31:0] pick(input logic [255:0] regs, input logic [2:0] n);
        pick = regs[n*32 +: 32];
    endfunction

    eagen_pkg::request_t r;
    assign r = I_REQ;
    // Base and index selection.
    wire logic [31:0] addr_reg_n = pick(I_ADDR_REGS, r.reg_num);
    wire logic [31:0] data_reg_n = pick(I_DATA_REGS, r.reg_num);
    wire logic [31:0] index_raw = r.index_is_addr ? pick(I_ADDR_REGS, r.index_num)
                                                  : pick(I_DATA_REGS, r.index_num);
    wire logic [31:0] index_reg = r.index_long ? index_raw : sext16(index_raw[15:0]);
    wire logic [31:0] long_displacement = sext16(r.ext_word0);
    wire logic [31:0] short_displacement = sext8(r.ext_word0[7:0]);
    // Step size by operand size; bit and BCD operands use the byte step.
    wire logic [31:0] step = (r.size == eagen_pkg::SZ_LONG) ? `STEP_LONG :
                             (r.size == eagen_pkg::SZ_WORD) ? `STEP_WORD : `STEP_BYTE;
    wire logic [31:0] ptr_inc = addr_reg_n + step;
    wire logic [31:0] ptr_dec = addr_reg_n - step;
    wire logic [31:0] imm_val = (r.size == eagen_pkg::SZ_LONG) ? {r.ext_word0, r.ext_word1} :
                                (r.size == eagen_pkg::SZ_WORD) ? {16'h0000, r.ext_word0} :
                                ({16'h0000, r.ext_word0} & `BYTE_MASK);
    wire logic [31:0] implied_val = (r.implied_sel == eagen_pkg::IMP_SR) ? I_STATUS :
                                    (r.implied_sel == eagen_pkg::IMP_USP) ? I_USER_STACK_PTR :
                                    (r.implied_sel == eagen_pkg::IMP_SP) ?
                                    pick(I_ADDR_REGS, `SP_REG_NUM)
                                    : I_PC;

    eagen_pkg::result_t res_d;
    eagen_pkg::result_t res_q;
    logic valid_q;

    // Mode decode; each branch gives the operand address or the operand itself.
    always_comb begin
        res_d = '0;
        res_d.ptr_num = r.reg_num;
        case (r.mode)
            eagen_pkg::M_DATA_DIRECT: res_d.value = data_reg_n;
            eagen_pkg::M_ADDR_DIRECT: res_d.value = addr_reg_n;
            eagen_pkg::M_ABS_SHORT: begin
                res_d.is_address = 1'b1;
                res_d.value = sext16(r.ext_word0);
            end
            eagen_pkg::M_ABS_LONG: begin
                res_d.is_address = 1'b1;
                res_d.value = {r.ext_word0, r.ext_word1};
            end
            eagen_pkg::M_PC_DISP: begin
                res_d.is_address = 1'b1;
                res_d.value = I_PC + long_displacement;
            end
            eagen_pkg::M_PC_INDEX: begin
                res_d.is_address = 1'b1;
                res_d.value = I_PC + index_reg + short_displacement;
            end
            eagen_pkg::M_INDIRECT: begin
                res_d.is_address = 1'b1;
                res_d.value = addr_reg_n;
            end
            eagen_pkg::M_POSTINC: begin
                res_d.is_address = 1'b1;
                res_d.value = addr_reg_n;
                res_d.ptr_write = 1'b1;
                res_d.ptr_value = ptr_inc;
            end
            eagen_pkg::M_PREDEC: begin
                res_d.is_address = 1'b1;
                res_d.value = ptr_dec;
                res_d.ptr_write = 1'b1;
                res_d.ptr_value = ptr_dec;
            end
            eagen_pkg::M_DISP: begin
                res_d.is_address = 1'b1;
                res_d.value = addr_reg_n + long_displacement;
            end
            eagen_pkg::M_INDEX: begin
                res_d.is_address = 1'b1;
                res_d.value = addr_reg_n + index_reg + short_displacement;
            end
            eagen_pkg::M_IMMEDIATE: res_d.value = imm_val;
            eagen_pkg::M_QUICK: res_d.value = sext8(r.quick_data);
            eagen_pkg::M_IMPLIED: res_d.value = implied_val;
            default: res_d = '0;
        endcase
        if (!I_REQ_VALID) begin
            res_d = '0;
        end
    end

    // Result register; cleared on reset and on idle cycles.
    always_ff @(posedge I_CLK) begin
        if (!I_RESET_N) begin
            res_q <= '0;
            valid_q <= 1'b0;
        end else begin
            res_q <= res_d;
            valid_q <= I_REQ_VALID;
        end
    end
    assign O_VALID = valid_q;
    assign O_RESULT = res_q;

    // Checks next to the datapath.
    a_postinc_step: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
        I_REQ_VALID && r.mode == eagen_pkg::M_POSTINC |=>
        O_RESULT.ptr_value == O_RESULT.value + $past(step))
        else $error("postincrement pointer wrong");
    a_predec_use: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
        I_REQ_VALID && r.mode == eagen_pkg::M_PREDEC |=>
        O_RESULT.value == $past(addr_reg_n) - $past(step) && O_RESULT.ptr_write)
        else $error("predecrement address wrong");
    a_step_long: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
        I_REQ_VALID && r.mode == eagen_pkg::M_POSTINC && r.size == eagen_pkg::SZ_LONG |=>
        O_RESULT.ptr_value - O_RESULT.value == `STEP_LONG)
        else $error("long step is not four");
    a_step_byte: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
        I_REQ_VALID && r.mode == eagen_pkg::M_PREDEC && r.size == eagen_pkg::SZ_BYTE |=>
        O_RESULT.value == $past(addr_reg_n) - `STEP_BYTE)
        else $error("byte step is not one");
    a_disp_sum: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
        I_REQ_VALID && r.mode == eagen_pkg::M_DISP |=>
        O_RESULT.value == $past(addr_reg_n) + sext16($past(r.ext_word0)))
        else $error("displacement address wrong");
    a_pc_index: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
        I_REQ_VALID && r.mode == eagen_pkg::M_PC_INDEX |=>
        O_RESULT.value == $past(I_PC) + $past(index_reg) + sext8($past(r.ext_word0[7:0])))
        else $error("indexed pc address wrong");
    a_abs_long: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
        I_REQ_VALID && r.mode == eagen_pkg::M_ABS_LONG |=>
        O_RESULT.value == {$past(r.ext_word0), $past(r.ext_word1)} && O_RESULT.is_address)
        else $error("absolute long address wrong");
    a_no_ptr_write: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
        O_RESULT.ptr_write |-> O_VALID && $past(r.mode == eagen_pkg::M_POSTINC
        || r.mode == eagen_pkg::M_PREDEC))
        else $error("unexpected pointer write");
    a_valid_follow: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
        !I_REQ_VALID |=> !O_VALID && O_RESULT == '0)
        else $error("result not idle");
    // Absolute short must widen its single word with the sign, not with zeros.
    a_abs_short: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
        I_REQ_VALID && r.mode == eagen_pkg::M_ABS_SHORT |=>
        O_RESULT.value == sext16($past(r.ext_word0)) && O_RESULT.is_address)
        else $error("absolute short address wrong");
    // Relative addressing uses the program counter of the request cycle.
    a_pc_disp: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
        I_REQ_VALID && r.mode == eagen_pkg::M_PC_DISP |=>
        O_RESULT.value == $past(I_PC) + sext16($past(r.ext_word0)))
        else $error("pc displacement address wrong");
    // Indexed indirect is a three-way sum.
    a_index_sum: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
        I_REQ_VALID && r.mode == eagen_pkg::M_INDEX |=>
        O_RESULT.value == $past(addr_reg_n) + $past(index_reg)
        + sext8($past(r.ext_word0[7:0])))
        else $error("indexed address wrong");
    // A data register chosen as index must be read from the data bank.
    a_index_data: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
        I_REQ_VALID && r.mode == eagen_pkg::M_INDEX && !r.index_is_addr && r.index_long |=>
        O_RESULT.value == $past(addr_reg_n) + $past(pick(I_DATA_REGS, r.index_num))
        + sext8($past(r.ext_word0[7:0])))
        else $error("data index source wrong");
    // A word index only counts its low half, widened with the sign.
    a_word_index: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
        I_REQ_VALID && r.mode == eagen_pkg::M_INDEX && !r.index_long |=>
        O_RESULT.value == $past(addr_reg_n) + sext16($past(index_raw[15:0]))
        + sext8($past(r.ext_word0[7:0])))
        else $error("word index not sign extended");
    // Quick data is an operand, never an address.
    a_quick_data: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
        I_REQ_VALID && r.mode == eagen_pkg::M_QUICK |=>
        O_RESULT.value == sext8($past(r.quick_data)) && !O_RESULT.is_address)
        else $error("quick operand wrong");
    // Data register direct hands the register itself over.
    a_data_direct: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
        I_REQ_VALID && r.mode == eagen_pkg::M_DATA_DIRECT |=>
        O_RESULT.value == $past(data_reg_n) && !O_RESULT.is_address)
        else $error("data direct operand wrong");
    // The active stack pointer is address register seven.
    a_implied_sp: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
        I_REQ_VALID && r.mode == eagen_pkg::M_IMPLIED && r.implied_sel == eagen_pkg::IMP_SP |=>
        O_RESULT.value == $past(pick(I_ADDR_REGS, `SP_REG_NUM)))
        else $error("implied stack pointer wrong");
    // Word operands step the pointer by two.
    a_step_word: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
        I_REQ_VALID && r.mode == eagen_pkg::M_POSTINC && r.size == eagen_pkg::SZ_WORD |=>
        O_RESULT.ptr_value - O_RESULT.value == `STEP_WORD)
        else $error("word step is not two");
    // Long immediate takes the high half from the first extension word.
    a_imm_long: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
        I_REQ_VALID && r.mode == eagen_pkg::M_IMMEDIATE && r.size == eagen_pkg::SZ_LONG |=>
        O_RESULT.value == {$past(r.ext_word0), $past(r.ext_word1)})
        else $error("long immediate wrong");
    // Plain indirect must leave the pointer alone.
    a_indirect: assert property (@(posedge I_CLK) disable iff (!I_RESET_N)
        I_REQ_VALID && r.mode == eagen_pkg::M_INDIRECT |=>
        O_RESULT.value == $past(addr_reg_n) && O_RESULT.is_address && !O_RESULT.ptr_write)
        else $error("register indirect wrong");
endmodule

// >>> testbench/eagen_partner.sv
// Purpose: Register file seen by the address generator, with pointer write-back.
// Assumes: Pointer updates come only from reported results, one per valid cycle.
// Notes: Values load while reset is low, so the bench picks the start contents.
`timescale 1ns/1ps
module eagen_partner (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic [255:0] i_init_data,
    input wire logic [255:0] i_init_addr,
    input wire logic i_valid,
    input wire eagen_pkg::result_t i_result,
    output logic [255:0] o_data_regs,
    output logic [255:0] o_addr_regs
);
    // Write-back lands one edge after the result, so a request in between sees old values.
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            o_data_regs <= i_init_data;
            o_addr_regs <= i_init_addr;
        end else if (i_valid && i_result.ptr_write) begin
            o_addr_regs[i_result.ptr_num*32 +: 32] <= i_result.ptr_value;
        end
    end
endmodule

// >>> testbench/effective_address_generator_bench.sv
// Purpose: Random self-checking bench comparing every result with a queue model.
// Assumes: One request per cycle at most, result exactly one edge later.
// Notes: Outputs are checked at the falling edge, just before the next drive.
`timescale 1ns/1ps
module effective_address_generator_bench;
    logic I_CLK = 1'b0, I_RESET_N = 1'b0, I_REQ_VALID = 1'b0, O_VALID;
    logic [255:0] dregs, aregs, init_d = '0, init_a = '0;
    logic [31:0] I_PC = '0, I_STATUS = '0, I_USER_STACK_PTR = '0, s = 32'h7A5E481A;
    eagen_pkg::request_t I_REQ = '0;
    eagen_pkg::result_t O_RESULT, e;
    eagen_pkg::result_t exp_q[$];
    int err_count = 0, n_checks = 0;
    // Clock at 25 MHz.
    always #20 I_CLK = ~I_CLK;
    effective_address_generator dut (.I_CLK(I_CLK), .I_RESET_N(I_RESET_N),
        .I_REQ_VALID(I_REQ_VALID), .I_REQ(I_REQ), .I_DATA_REGS(dregs), .I_ADDR_REGS(aregs),
        .I_PC(I_PC), .I_STATUS(I_STATUS), .I_USER_STACK_PTR(I_USER_STACK_PTR),
        .O_VALID(O_VALID), .O_RESULT(O_RESULT));
    eagen_partner regs (.i_clk(I_CLK), .i_reset_n(I_RESET_N), .i_init_data(init_d),
        .i_init_addr(init_a), .i_valid(O_VALID), .i_result(O_RESULT),
        .o_data_regs(dregs), .o_addr_regs(aregs));
    function logic [31:0] nxt(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    function logic [31:0] sx(input logic [15:0] v);
        return {{16{v[15]}}, v};
    endfunction
    // Reference behaviour, written straight from the addressing table.
    function eagen_pkg::result_t model(input eagen_pkg::request_t q);
        logic [31:0] a, x, n, d8;
        eagen_pkg::result_t r;
        a = aregs[q.reg_num*32 +: 32];
        x = q.index_is_addr ? aregs[q.index_num*32 +: 32] : dregs[q.index_num*32 +: 32];
        if (!q.index_long) x = sx(x[15:0]);
        n = 32'h00000001 << q.size;
        d8 = {{24{q.ext_word0[7]}}, q.ext_word0[7:0]};
        r = '0;
        r.is_address = 1'b1;
        case (q.mode)
            eagen_pkg::M_DATA_DIRECT: r.value = dregs[q.reg_num*32 +: 32];
            eagen_pkg::M_ADDR_DIRECT: r.value = a;
            eagen_pkg::M_ABS_SHORT: r.value = sx(q.ext_word0);
            eagen_pkg::M_ABS_LONG: r.value = {q.ext_word0, q.ext_word1};
            eagen_pkg::M_PC_DISP: r.value = I_PC + sx(q.ext_word0);
            eagen_pkg::M_PC_INDEX: r.value = I_PC + x + d8;
            eagen_pkg::M_INDIRECT, eagen_pkg::M_POSTINC: r.value = a;
            eagen_pkg::M_PREDEC: r.value = a - n;
            eagen_pkg::M_DISP: r.value = a + sx(q.ext_word0);
            eagen_pkg::M_INDEX: r.value = a + x + d8;
            eagen_pkg::M_IMMEDIATE: r.value = (q.size == eagen_pkg::SZ_BYTE) ?
                {24'h000000, q.ext_word0[7:0]} : (q.size == eagen_pkg::SZ_WORD) ?
                {16'h0000, q.ext_word0} : {q.ext_word0, q.ext_word1};
            eagen_pkg::M_QUICK: r.value = {{24{q.quick_data[7]}}, q.quick_data};
            default: r.value = (q.implied_sel == eagen_pkg::IMP_SR) ? I_STATUS :
                (q.implied_sel == eagen_pkg::IMP_USP) ? I_USER_STACK_PTR :
                (q.implied_sel == eagen_pkg::IMP_SP) ? aregs[255:224] : I_PC;
        endcase
        if (q.mode inside {eagen_pkg::M_DATA_DIRECT, eagen_pkg::M_ADDR_DIRECT,
            eagen_pkg::M_IMMEDIATE, eagen_pkg::M_QUICK, eagen_pkg::M_IMPLIED}) r.is_address = 1'b0;
        r.ptr_write = q.mode inside {eagen_pkg::M_POSTINC, eagen_pkg::M_PREDEC};
        r.ptr_num = q.reg_num;
        r.ptr_value = (q.mode == eagen_pkg::M_POSTINC) ? a + n : a - n;
        return r;
    endfunction
    task automatic cmp(input string nm, input logic [31:0] ex, input logic [31:0] got);
        n_checks++;
        if (got !== ex) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", nm, ex, got);
        end
    endtask
    // An idle cycle must leave the result cleared, so a stale answer cannot pass.
    task automatic check_out();
        if (exp_q.size() == 0) begin
            cmp("idle valid", 32'h00000000, {31'h0, O_VALID});
            cmp("idle value", 32'h00000000, O_RESULT.value);
        end else begin
            e = exp_q.pop_front();
            cmp("valid", 32'h00000001, {31'h0, O_VALID});
            cmp("is_address", {31'h0, e.is_address}, {31'h0, O_RESULT.is_address});
            cmp("value", e.value, O_RESULT.value);
            cmp("ptr_write", {31'h0, e.ptr_write}, {31'h0, O_RESULT.ptr_write});
            if (e.ptr_write) cmp("ptr_num", {29'h0, e.ptr_num}, {29'h0, O_RESULT.ptr_num});
            if (e.ptr_write) cmp("ptr_value", e.ptr_value, O_RESULT.ptr_value);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // Watchdog sized well above the 410 cycles that the tests need.
    initial begin
        #(40 * 2000);
        err_count++;
        finish_test();
    end
    // Random back-to-back traffic with about one idle cycle in four.
    initial begin
        for (int i = 0; i < 16; i++) begin
            s = nxt(s);
            if (i < 8) init_d[i*32 +: 32] = s;
            else init_a[(i-8)*32 +: 32] = s;
        end
        repeat (8) @(negedge I_CLK);
        check_out();
        I_RESET_N = 1'b1;
        $display("test reset done");
        repeat (400) @(negedge I_CLK) begin
            check_out();
            repeat (5) s = nxt(s);
            I_REQ.mode = eagen_pkg::mode_t'(4'(s[7:4] % 4'hE));
            I_REQ.size = eagen_pkg::size_t'(s[9:8] % 2'h3);
            {I_REQ.reg_num, I_REQ.index_is_addr, I_REQ.index_num} = s[16:10];
            {I_REQ.index_long, I_REQ.implied_sel, I_REQ.quick_data} = s[27:17];
            I_REQ.ext_word0 = s[31:16] ^ s[15:0];
            I_REQ.ext_word1 = s[15:0];
            {I_PC, I_STATUS, I_USER_STACK_PTR} = {s, ~s, {s[15:0], s[31:16]}};
            I_REQ_VALID = s[0] | s[1];
            if (I_REQ_VALID) exp_q.push_back(model(I_REQ));
        end
        @(negedge I_CLK) check_out();
        I_REQ_VALID = 1'b0;
        @(negedge I_CLK) check_out();
        $display("test random traffic done");
        finish_test();
    end
endmodule
